// ---- core/strap_cfg_pkg.sv ----
// Function
// - host holds reset low at least 1 us; device then runs full reset
// - reset returns the control, mask and status registers to their defaults
// - every reset captures all straps again, replacing old values
// - strap pins sampled while reset active; captured levels select modes
// - after reset each shared pin defaults to power-down input
// - pin driven low in input role puts port into power-down
// - interrupt role: open-drain, pulled low on interrupt, else released
// - pin becomes interrupt only after software register write
// - four address straps latched as management address bits 4..1
// - address bit 0 fixed by port: A zero, B one
// - port A answers even addresses 0 to 30
// - port B answers odd address with same upper bits, 1 to 31
// - unconnected address straps read zero
// - fiber strap defaults off; sampled high enables fiber
// - autoneg strap low forces speed and duplex from mode bits
// - mode bits: tied low reads zero, tied high reads one
package strap_cfg_pkg;
  // ******************************************************
  // register map
  // ******************************************************
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STRAPA = 12'h004;
  localparam logic [11:0] ADDR_STRAPB = 12'h008;
  localparam logic [11:0] ADDR_STAT   = 12'h00C;
  localparam logic [11:0] ADDR_MASK   = 12'h010;
  // ctrl fields
  localparam int CTRL_IRQ_A = 0;
  localparam int CTRL_IRQ_B = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0]  MASK_RESET = 2'h0;
  // strap register fields
  localparam int STRAP_ADDR_LSB = 0;
  localparam int STRAP_FIBER    = 5;
  localparam int STRAP_AUTONEG  = 6;
  localparam int STRAP_MODE_LSB = 7;
  // strap defaults: address/fiber pull-down, autoneg/mode pull-up
  localparam logic [3:0] ADDR_STRAP_DFLT = 4'h0;
  localparam logic       FIBER_DFLT      = 1'b0;
  localparam logic       AUTONEG_DFLT    = 1'b1;
  localparam logic [1:0] MODE_DFLT       = 2'h3;
  // timing
  localparam int CLK_MHZ       = 100;
  localparam int RESET_MIN_NS  = 1000;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
endpackage

// ---- core/strap_sync_latch.sv ----
`timescale 1ns/1ns
`default_nettype none
// ******************************************************
// per-port strap capture register
// ******************************************************
module strap_sync_latch #(
  parameter int           W    = 8,
  parameter logic [W-1:0] DFLT = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         capture,
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] q
);
  // a strap word needs at least one bit
  if (W < 1) begin : g_bad_w
    $error("strap width must be positive");
  end
  logic [W-1:0] q_r;
  // captured while reset held, frozen afterwards
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= DFLT;
    end else if (capture) begin
      q_r <= pins;
    end
  end
  assign q = q_r;
endmodule
`default_nettype wire

// ---- core/reset_strap_config_latch.sv ----
`timescale 1ns/1ns
`default_nettype none
module reset_strap_config_latch (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        hw_reset_n,
  input  wire logic [3:0]  mgmt_addr_strap,
  input  wire logic [1:0]  fiber_enable_strap,
  input  wire logic [1:0]  autoneg_enable_strap,
  input  wire logic [1:0]  mode_select_bit0,
  input  wire logic [1:0]  mode_select_bit1,
  input  wire logic        port_a_sleep_or_irq_pin_i,
  input  wire logic        port_b_sleep_or_irq_pin_i,
  input  wire logic [1:0]  irq_event,
  input  wire logic [4:0]  mgmt_query_addr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic             port_a_sleep_or_irq_pin_o,
  output logic             port_a_sleep_or_irq_pin_oe,
  output logic             port_b_sleep_or_irq_pin_o,
  output logic             port_b_sleep_or_irq_pin_oe,
  output logic      [1:0]  power_down,
  output logic      [1:0]  mgmt_addr_hit,
  output logic      [1:0]  forced_mode,
  output logic      [1:0]  fiber_mode,
  output logic      [1:0]  in_reset
);
  // ******************************************************
  // reset pulse qualification
  // ******************************************************
  localparam int CW = $clog2(strap_cfg_pkg::RESET_MIN_CYC + 1);
  localparam logic [CW-1:0] CMAX = CW'(strap_cfg_pkg::RESET_MIN_CYC);
  logic [CW-1:0] low_cnt_r;
  logic          in_rst_r;
  wire           cnt_full = (low_cnt_r == CMAX);
  // count low cycles of the host reset; short glitches ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_r <= '0;
    end else if (hw_reset_n) begin
      low_cnt_r <= '0;
    end else if (!cnt_full) begin
      low_cnt_r <= low_cnt_r + CW'(1);
    end
  end
  // reset process runs from a qualified pulse until release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_rst_r <= 1'b1;
    end else begin
      in_rst_r <= (!hw_reset_n && cnt_full) || (in_rst_r && !hw_reset_n);
    end
  end
  wire soft_clr = in_rst_r;

  // ******************************************************
  // strap capture
  // ******************************************************
  logic [8:0] strap_q [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_port
      wire [8:0] pin_vec = {mode_select_bit1[g], mode_select_bit0[g], autoneg_enable_strap[g],
                            fiber_enable_strap[g], mgmt_addr_strap, 1'(g)};
      // pin defaults of this port, held until the first capture
      localparam logic [8:0] PORT_DFLT = {strap_cfg_pkg::MODE_DFLT, strap_cfg_pkg::AUTONEG_DFLT,
                                          strap_cfg_pkg::FIBER_DFLT, strap_cfg_pkg::ADDR_STRAP_DFLT, 1'(g)};
      strap_sync_latch #(
        .W    (9),
        .DFLT (PORT_DFLT)
      ) u_latch (
        .pclk    (pclk),
        .presetn (presetn),
        .capture (in_rst_r),
        .pins    (pin_vec),
        .q       (strap_q[g])
      );
    end
  endgenerate

  // ******************************************************
  // decode helpers
  // ******************************************************
  function automatic logic [4:0] addr_of(input logic [8:0] s);
    addr_of = s[4:0];
  endfunction
  wire [4:0] addr_a = addr_of(strap_q[0]);
  wire [4:0] addr_b = addr_of(strap_q[1]);
  wire       hit_a  = (mgmt_query_addr == addr_a);
  wire       hit_b  = (mgmt_query_addr == addr_b);

  // ******************************************************
  // registers
  // ******************************************************
  logic [1:0]  irq_role_r;
  logic [1:0]  stat_r;
  logic [1:0]  mask_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  // bus phases: setup snapshots read data, completion commits a write
  wire acc    = psel && !penable;
  wire done   = psel && penable && pready_r;
  wire wr     = done && pwrite;
  wire rd     = acc && !pwrite;
  // address decode
  wire sel_c  = (paddr == strap_cfg_pkg::ADDR_CTRL);
  wire sel_a  = (paddr == strap_cfg_pkg::ADDR_STRAPA);
  wire sel_b  = (paddr == strap_cfg_pkg::ADDR_STRAPB);
  wire sel_s  = (paddr == strap_cfg_pkg::ADDR_STAT);
  wire sel_m  = (paddr == strap_cfg_pkg::ADDR_MASK);
  wire mapped = sel_c | sel_a | sel_b | sel_s | sel_m;
  // read data select
  wire [31:0] rmux = sel_c ? {30'h0, irq_role_r} :
                     sel_a ? {23'h0, strap_q[0]} :
                     sel_b ? {23'h0, strap_q[1]} :
                     sel_s ? {30'h0, stat_r} :
                     sel_m ? {30'h0, mask_r} : 32'h0;
  // role control: only software moves pin to interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_role_r <= 2'h0;
    end else if (soft_clr) begin
      irq_role_r <= 2'h0;
    end else if (wr && sel_c) begin
      irq_role_r <= pwdata[1:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= strap_cfg_pkg::MASK_RESET;
    end else if (soft_clr) begin
      mask_r <= strap_cfg_pkg::MASK_RESET;
    end else if (wr && sel_m) begin
      mask_r <= pwdata[1:0];
    end
  end
  // sticky status, read clears, set wins
  wire [1:0] stat_nxt = ((rd && sel_s) ? 2'h0 : stat_r) | irq_event;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 2'h0;
    end else if (soft_clr) begin
      stat_r <= 2'h0;
    end else begin
      stat_r <= stat_nxt;
    end
  end
  // apb ready one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= acc;
    end
  end
  // error answer for an unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= acc && !mapped;
    end
  end
  // read data snapshot taken at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= rd ? rmux : 32'h0000_0000;
    end
  end

  // ******************************************************
  // strap field views
  // ******************************************************
  // one bit of a captured strap word, picked by field position
  function automatic logic strap_bit(input logic [8:0] s, input int pos);
    strap_bit = s[pos];
  endfunction
  // per-port fields of the captured words; fixed between resets
  wire       fiber_a   = strap_bit(strap_q[0], strap_cfg_pkg::STRAP_FIBER);
  wire       fiber_b   = strap_bit(strap_q[1], strap_cfg_pkg::STRAP_FIBER);
  wire       autoneg_a = strap_bit(strap_q[0], strap_cfg_pkg::STRAP_AUTONEG);
  wire       autoneg_b = strap_bit(strap_q[1], strap_cfg_pkg::STRAP_AUTONEG);
  // mode pair, bit 1 above bit 0
  wire [1:0] mode_a    = strap_q[0][strap_cfg_pkg::STRAP_MODE_LSB +: 2];
  wire [1:0] mode_b    = strap_q[1][strap_cfg_pkg::STRAP_MODE_LSB +: 2];

  // ******************************************************
  // pins and mode outputs
  // ******************************************************
  // interrupt causes that software let through
  wire [1:0] pend  = stat_r & mask_r;
  // pin levels, port a in bit 0
  wire [1:0] pin_i = {port_b_sleep_or_irq_pin_i, port_a_sleep_or_irq_pin_i};
  // next values of the pin and mode flops
  wire [1:0] oe_nxt     = irq_role_r & pend;
  wire [1:0] pd_nxt     = ~irq_role_r & ~pin_i;
  wire [1:0] hit_nxt    = in_rst_r ? 2'h0 : {hit_b, hit_a};
  wire [1:0] forced_nxt = ~{autoneg_b, autoneg_a};
  wire [1:0] fiber_nxt  = {fiber_b, fiber_a};
  wire       irq_nxt    = |pend;
  // flops behind every pin enable and mode output
  logic [1:0] oe_r;
  logic [1:0] pd_r;
  logic [1:0] hit_r;
  logic [1:0] forced_r;
  logic [1:0] fiber_r;
  logic       irq_r;
  // open-drain enable: pulls low only in interrupt role
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_r <= 2'h0;
    end else begin
      oe_r <= oe_nxt;
    end
  end
  // power-down request from a low pin in input role
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_r <= 2'h0;
    end else begin
      pd_r <= pd_nxt;
    end
  end
  // management address match, quiet during reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_r <= 2'h0;
    end else begin
      hit_r <= hit_nxt;
    end
  end
  // forced mode when autoneg strap low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      forced_r <= 2'h0;
    end else begin
      forced_r <= forced_nxt;
    end
  end
  // fiber mode from its strap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fiber_r <= 2'h0;
    end else begin
      fiber_r <= fiber_nxt;
    end
  end
  // level interrupt while a let-through cause is pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // ******************************************************
  // output ports
  // ******************************************************
  // open-drain pins only ever pull low
  assign port_a_sleep_or_irq_pin_o  = 1'b0;
  assign port_b_sleep_or_irq_pin_o  = 1'b0;
  // enables and flags straight from flops
  assign port_a_sleep_or_irq_pin_oe = oe_r[0];
  assign port_b_sleep_or_irq_pin_oe = oe_r[1];
  assign power_down    = pd_r;
  assign mgmt_addr_hit = hit_r;
  assign forced_mode   = forced_r;
  assign fiber_mode    = fiber_r;
  assign irq           = irq_r;
  // bus answer flops
  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  // one reset flag seen by both ports
  assign in_reset      = {in_rst_r, in_rst_r};

  // ******************************************************
  // checks
  // ******************************************************
  // reset qualification
  a_short_pulse_ign: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(hw_reset_n) && !in_rst_r) |=> !in_rst_r) else $error("short reset acted");
  a_in_reset_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (in_rst_r && !hw_reset_n) |=> in_rst_r) else $error("reset process cut short");
  a_qualified_enter: assert property (@(posedge pclk) disable iff (!presetn)
    (!hw_reset_n && cnt_full) |=> in_rst_r) else $error("long pulse ignored");
  a_reset_clears_role: assert property (@(posedge pclk) disable iff (!presetn)
    in_rst_r |=> irq_role_r == 2'h0 && mask_r == 2'h0) else $error("reg not reset");

  // strap capture and hold
  a_strap_recapture: assert property (@(posedge pclk) disable iff (!presetn)
    in_rst_r |=> strap_q[0][4:1] == $past(mgmt_addr_strap)) else $error("strap not captured");
  a_fiber_capture: assert property (@(posedge pclk) disable iff (!presetn)
    in_rst_r |=> fiber_a == $past(fiber_enable_strap[0])) else $error("fiber strap not captured");
  a_mode_capture: assert property (@(posedge pclk) disable iff (!presetn)
    in_rst_r |=> mode_a == $past({mode_select_bit1[0], mode_select_bit0[0]}) &&
                 mode_b == $past({mode_select_bit1[1], mode_select_bit0[1]})) else $error("mode not captured");
  a_strap_held: assert property (@(posedge pclk) disable iff (!presetn)
    !in_rst_r && !$past(in_rst_r) |-> $stable(strap_q[1])) else $error("strap changed");
  a_strap_held_a: assert property (@(posedge pclk) disable iff (!presetn)
    !in_rst_r && !$past(in_rst_r) |-> $stable(strap_q[0])) else $error("strap a changed");
  a_port_lsb_fixed: assert property (@(posedge pclk) disable iff (!presetn)
    !in_rst_r |-> !addr_a[0] && addr_b[0] && addr_a[4:1] == addr_b[4:1]) else $error("addr lsb");
  a_forced_mode: assert property (@(posedge pclk) disable iff (!presetn)
    !strap_q[0][strap_cfg_pkg::STRAP_AUTONEG] |=> forced_r[0]) else $error("not forced");

  // shared pin roles
  a_pd_input: assert property (@(posedge pclk) disable iff (!presetn)
    (!irq_role_r[0] && !pin_i[0]) |=> pd_r[0]) else $error("no power down");
  a_pd_role_block: assert property (@(posedge pclk) disable iff (!presetn)
    irq_role_r[0] |=> !pd_r[0]) else $error("power down in interrupt role");
  a_od_release: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_role_r[1] |=> !oe_r[1]) else $error("pin driven in input role");
  a_od_pull: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_role_r[0] && pend[0]) |=> oe_r[0]) else $error("interrupt pin not pulled");
  a_role_by_write: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(irq_role_r[0]) |-> $past(wr && sel_c)) else $error("role changed alone");

  // status and bus answer
  a_stat_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_event[0] && !soft_clr) |=> stat_r[0]) else $error("event lost");
  a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && sel_s && irq_event == 2'h0 && !soft_clr) |=> stat_r == 2'h0) else $error("status not cleared");
  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    (pend != 2'h0) |=> irq_r) else $error("irq missing");
  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pready_r |=> !pready_r) else $error("ready held");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (acc && !mapped) |=> pslverr_r) else $error("no error answer");
  // main scenarios
  c_irq_pin: cover property (@(posedge pclk) disable iff (!presetn) oe_r[0]);
  c_reset_seen: cover property (@(posedge pclk) disable iff (!presetn) $fell(in_rst_r));
  c_hit_b: cover property (@(posedge pclk) disable iff (!presetn) hit_r[1]);
  c_short_pulse: cover property (@(posedge pclk) disable iff (!presetn) $rose(hw_reset_n) && !in_rst_r);
  c_status_clear: cover property (@(posedge pclk) disable iff (!presetn) rd && sel_s && stat_r != 2'h0);
endmodule
`default_nettype wire

// ---- verif/strap_board_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ******************************
// host reset driver and straps
// ******************************
module strap_board_model (
  input  wire logic        pclk,
  input  wire logic [1:0]  pin_oe,
  input  wire logic [1:0]  host_sleep_n,
  output logic             hw_reset_n,
  output logic      [11:0] straps,
  output logic      [1:0]  pin_level
);
  // address and fiber pull down, autoneg and mode pull up
  localparam logic [11:0] PULL = 12'hFC0;
  logic [11:0] val_r;
  logic        drive_r;
  logic        tog_r = 1'b0;
  // board idle at power-up
  initial begin
    hw_reset_n = 1'b1;
    val_r = PULL;
    drive_r = 1'b0;
  end
  // after reset the strap pins run as outputs with a changing pattern
  always @(posedge pclk) tog_r <= ~tog_r;
  assign straps = drive_r ? val_r ^ {12{tog_r}} : val_r;
  // open-drain wire with pull-up
  assign pin_level = ~pin_oe & host_sleep_n;
  // low pulse on the reset pin, straps held while it is low
  task automatic pulse_reset(input logic [11:0] v, input bit fit, input int cyc);
    drive_r <= 1'b0;
    val_r <= fit ? v : PULL;
    hw_reset_n <= 1'b0;
    repeat (cyc) @(posedge pclk);
    hw_reset_n <= 1'b1;
    repeat (3) @(posedge pclk);
    drive_r <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, hw_n, pready, pslverr, irq;
  logic [11:0] paddr, straps, v;
  logic [31:0] pwdata, prdata;
  logic [4:0]  qaddr;
  logic [1:0]  ev, sleep_n, lvl, oe, po, pd, hit, fm, fib, inr;
  logic [32:0] exp_q[$];
  int          err_total = 0;
  int          samples_checked = 0;
  // 100 MHz clock
  always #5 pclk = ~pclk;
  reset_strap_config_latch dut (
    .pclk(pclk), .presetn(presetn), .hw_reset_n(hw_n), .mgmt_addr_strap(straps[3:0]),
    .fiber_enable_strap(straps[5:4]), .autoneg_enable_strap(straps[7:6]),
    .mode_select_bit0(straps[9:8]), .mode_select_bit1(straps[11:10]),
    .port_a_sleep_or_irq_pin_i(lvl[0]), .port_b_sleep_or_irq_pin_i(lvl[1]),
    .irq_event(ev), .mgmt_query_addr(qaddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .port_a_sleep_or_irq_pin_o(po[0]), .port_a_sleep_or_irq_pin_oe(oe[0]),
    .port_b_sleep_or_irq_pin_o(po[1]), .port_b_sleep_or_irq_pin_oe(oe[1]),
    .power_down(pd), .mgmt_addr_hit(hit), .forced_mode(fm), .fiber_mode(fib), .in_reset(inr));
  strap_board_model board (.pclk(pclk), .pin_oe(oe), .host_sleep_n(sleep_n), .hw_reset_n(hw_n),
    .straps(straps), .pin_level(lvl));
  // ******************************
  // tasks
  // ******************************
  task automatic finish_test;
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] e);
    samples_checked++;
    if (got !== e) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one apb transfer; a read notes {pslverr, prdata} expected
  task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    if (!w) exp_q.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // idle cycle keeps the next setup off this step
  endtask
  function automatic logic [32:0] sw(input logic [11:0] s, input logic p);
    return {24'h0, s[10+p], s[8+p], s[6+p], s[4+p], s[3:0], p};
  endfunction
  // read monitor takes the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite) chk({pslverr, prdata}, exp_q.pop_front());
  // watchdog
  initial begin
    #100000;
    err_total++;
    finish_test();
  end
  // ******************************
  // main sequence
  // ******************************
  initial begin
    void'($urandom(32'h0327));
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    qaddr = 5'h00;
    ev = 2'h0;
    sleep_n = 2'h3;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    cyc(3);
    for (int k = 0; k < 4; k++) begin
      v = 12'($urandom);
      fork
        board.pulse_reset(v, k > 0, strap_cfg_pkg::RESET_MIN_CYC + 2 + k);
        begin
          cyc(strap_cfg_pkg::RESET_MIN_CYC + 2);
          chk({31'h0, inr}, 33'h3);
        end
      join
      chk({31'h0, inr}, 33'h0);
      if (k == 0) v = 12'hFC0;
      apb(0, strap_cfg_pkg::ADDR_STRAPA, sw(v, 1'b0));
      apb(0, strap_cfg_pkg::ADDR_STRAPB, sw(v, 1'b1));
      apb(0, strap_cfg_pkg::ADDR_CTRL, 33'h0);
      apb(0, strap_cfg_pkg::ADDR_MASK, 33'h0);
      apb(0, 12'h014, 33'h1_0000_0000);
      chk({31'h0, fm}, {31'h0, ~v[7:6]});
      chk({31'h0, fib}, {31'h0, v[5:4]});
      for (int j = 0; j < 3; j++) begin
        qaddr <= {v[3:0] ^ {3'h0, j == 2}, j[0]};
        cyc(2);
        chk({31'h0, hit}, {31'h0, j == 2 ? 2'b00 : (j[0] ? 2'b10 : 2'b01)});
      end
      ev <= 2'h3;
      cyc(1);
      ev <= 2'h0;
      sleep_n <= 2'h2;
      cyc(3);
      chk({31'h0, oe}, 33'h0);
      chk({31'h0, po}, 33'h0);
      chk({31'h0, pd}, 33'h1);
      sleep_n <= 2'h3;
      apb(1, strap_cfg_pkg::ADDR_CTRL, 33'h3);
      chk({32'h0, irq}, 33'h0);
      chk({31'h0, pd}, 33'h0);
      apb(1, strap_cfg_pkg::ADDR_MASK, 33'h1);
      cyc(2);
      chk({30'h0, irq, lvl}, 33'h6);
      apb(0, strap_cfg_pkg::ADDR_STAT, 33'h3);
      cyc(2);
      chk({30'h0, irq, oe}, 33'h0);
    end
    // a pulse below the minimum leaves straps and registers alone
    board.pulse_reset(12'($urandom), 1'b1, 20);
    chk({31'h0, inr}, 33'h0);
    apb(0, strap_cfg_pkg::ADDR_STRAPA, sw(v, 1'b0));
    apb(0, strap_cfg_pkg::ADDR_STRAPB, sw(v, 1'b1));
    apb(0, strap_cfg_pkg::ADDR_CTRL, 33'h3);
    finish_test();
  end
endmodule
`default_nettype wire
